//--- hw/lacm_map.svh
// lacm_map.svh: offsets, fields, reset values and timing counts of the lamp alarm/cooldown manager
// assumes a 50 MHz system clock; times are kept in ms or s, derived to cycles in the design
`ifndef LACM_MAP_SVH
`define LACM_MAP_SVH
`define LACM_CLK_HZ      50000000
`define LACM_MS_PER_S    1000
`define LACM_FILT_MS     300
`define LACM_SHUT_MS     2000
`define LACM_FB_MS       2000
`define LACM_FLOW_MS     2000
`define LACM_WARM_S      180
`define LACM_COOL_MAX_S  180
`define LACM_COOL_MIN_S  30
`define LACM_SEC_PER_HR  3600
`define LACM_LED_ON_MS   250
`define LACM_LED_OFF_MS  250
`define LACM_FLICK_MS    50
`define LACM_LED_GAP_MS  1500
`define LACM_A_CTRL      8'h00
`define LACM_A_COOL      8'h04
`define LACM_A_KP        8'h08
`define LACM_A_KI        8'h0C
`define LACM_A_SETP      8'h10
`define LACM_A_HOURS     8'h14
`define LACM_A_CODE      8'h18
`define LACM_A_STAT      8'h1C
`define LACM_CTRL_VFD    0
`define LACM_CTRL_CLR    1
`define LACM_RST_COOL    16'h003C
`define LACM_RST_KP      8'h10
`define LACM_RST_KI      8'h02
`define LACM_RST_SETP    12'h190
`define LACM_C_FIRST_FLT 5'h07
`define LACM_C_WARM      10
`define LACM_C_STRIKE    11
`define LACM_C_UNLATCH   18
`define LACM_C_HOTSW     19
`define LACM_C_SHUT      20
`define LACM_C_FAN       21
`define LACM_C_FLOW      22
`define LACM_P_LAMP      0
`define LACM_P_ILOCK     1
`define LACM_P_THERM     2
`define LACM_P_SHUT      3
`define LACM_P_FAN       4
`define LACM_P_FLOW      5
`endif

//--- hw/lacm_pkg.sv
// lacm_pkg: types of the lamp alarm/cooldown manager
// assumes lacm_map.svh defines the numeric constants
package lacm_pkg;
   typedef enum logic [1:0] {LS_OFF, LS_ON, LS_COOL} lacm_lamp_t;
   typedef enum logic [1:0] {LP_GAP, LP_ON, LP_OFF} lacm_led_t;
   // software bus request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } lacm_bus_t;
   // complete state of the manager
   typedef struct packed {
      logic [5:0]        s1, s2, s3, pin;
      logic [1:0]        fval;
      logic [1:0][8:0]   fcnt;
      logic [15:0]       pre;
      logic [9:0]        ms_in_s;
      logic [11:0]       s_in_hr;
      logic [19:0]       hours;
      logic [2:0][11:0]  wd;
      logic [7:0]        warm_s;
      lacm_lamp_t        st;
      logic [15:0]       cool_s;
      logic              low_at_off;
      logic [22:0]       flt_lat;
      logic [4:0]        code;
      logic              alarm;
      lacm_led_t         lph;
      logic [10:0]       led_ms;
      logic [4:0]        led_i, led_code;
      logic              led_g, led_r;
      logic signed [15:0] integ;
      logic [7:0]        air;
      logic              vfd;
      logic [15:0]       cool_param;
      logic [7:0]        kp, ki;
      logic [11:0]       setp;
      logic [31:0]       rdata;
   } lacm_state_t;
endpackage

//--- hw/lacm_top.sv
// lacm_top: alarm classification, LED flash code, cooldown sequencing, hour meter
// assumes pins are asynchronous and active low; condition inputs and temperature are on clk
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "lacm_map.svh"
module lacm_top #(
   parameter int MS_CYC = `LACM_CLK_HZ / `LACM_MS_PER_S
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire lacm_pkg::lacm_bus_t bus,
   output logic [31:0]           rdata,
   input  wire logic             lamp_en_n,
   input  wire logic             interlock_n,
   input  wire logic             lamp_sw_n,
   input  wire logic             shutter_open_n,
   input  wire logic             fan_fb_n,
   input  wire logic             flow_ok_n,
   input  wire logic             shutter_cmd,
   input  wire logic             lamp_ignited,
   input  wire logic             lamp_ready,
   input  wire logic [11:0]      lamp_temp,
   input  wire logic [22:0]      cond_in,
   output logic                  lamp_on,
   output logic                  blower_on,
   output logic [7:0]            airflow,
   output logic                  alarm_out,
   output logic [4:0]            fault_code,
   output logic [19:0]           lamp_hours,
   output logic                  led_green,
   output logic                  led_red
);
   import lacm_pkg::*;

   // highest active code wins
   function automatic logic [4:0] top_code(input logic [22:0] act);
      top_code = 5'h00;
      for (int i = 1; i < 23; i++)
         if (act[i]) top_code = 5'(i);
   endfunction

   // flash count tied to each code
   function automatic logic [4:0] flashes(input logic [4:0] c);
      if (c <= 5'h02) flashes = (c == 5'h00) ? 5'h01 : c;
      else if (c <= 5'h06) flashes = c - 5'h02;
      else flashes = c - 5'h06;
   endfunction

   lacm_state_t r, n;
   logic [5:0]  pins_raw;
   logic        ms_tick, s_tick, fault_any, req, cool_done;
   logic [22:0] cur, act;
   logic [10:0] ph_len;
   logic signed [12:0] err;
   logic signed [21:0] pterm, iterm;
   logic signed [22:0] isum, osum;
   logic [31:0] rmux;

   // pins as active-high conditions
   assign pins_raw = {~flow_ok_n, ~fan_fb_n, ~shutter_open_n, ~lamp_sw_n, ~interlock_n, ~lamp_en_n};

   always_comb begin
      n = r;
      cur = cond_in;
      cur[0] = 1'b0;
      ph_len = 11'(`LACM_LED_ON_MS);
      rmux = 32'h0000_0000;
      err = 13'sh0000;
      pterm = 22'sh000000;
      iterm = 22'sh000000;
      isum = 23'sh000000;
      osum = 23'sh000000;
      cool_done = 1'b0;
      // three-stage sync, change taken when stages two and three agree
      n.s1 = pins_raw;
      n.s2 = r.s1;
      n.s3 = r.s2;
      for (int i = 0; i < 6; i++)
         if (r.s2[i] == r.s3[i]) n.pin[i] = r.s3[i];
      // ms and s time base
      ms_tick = (r.pre == 16'(MS_CYC - 1));
      n.pre = ms_tick ? 16'h0000 : r.pre + 16'h0001;
      s_tick = ms_tick && (r.ms_in_s == 10'(`LACM_MS_PER_S - 1));
      if (ms_tick) n.ms_in_s = s_tick ? 10'h000 : r.ms_in_s + 10'h001;
      // 300 ms persistence filter on interlock and thermal switch
      for (int i = 0; i < 2; i++) begin
         if (r.pin[`LACM_P_ILOCK + i] == r.fval[i]) n.fcnt[i] = 9'h000;
         else if (ms_tick) begin
            if (r.fcnt[i] == 9'(`LACM_FILT_MS - 1)) begin
               n.fval[i] = r.pin[`LACM_P_ILOCK + i];
               n.fcnt[i] = 9'h000;
            end else n.fcnt[i] = r.fcnt[i] + 9'h001;
         end
      end
      // ms watchdogs: shutter mismatch, fan feedback, airflow switch
      n.wd[0] = (shutter_cmd == r.pin[`LACM_P_SHUT]) ? 12'h000 : r.wd[0];
      n.wd[1] = (r.st == LS_OFF || r.pin[`LACM_P_FAN]) ? 12'h000 : r.wd[1];
      n.wd[2] = (r.st == LS_OFF || r.pin[`LACM_P_FLOW]) ? 12'h000 : r.wd[2];
      for (int i = 0; i < 3; i++)
         if (ms_tick && n.wd[i] != 12'(`LACM_FB_MS)) n.wd[i] = n.wd[i] + 12'h001;
      // internal detectors add to the external condition bits of the same code
      cur[`LACM_C_SHUT] = cur[`LACM_C_SHUT] | (r.wd[0] == 12'(`LACM_SHUT_MS));
      cur[`LACM_C_FAN]  = cur[`LACM_C_FAN] | (r.wd[1] == 12'(`LACM_FB_MS));
      cur[`LACM_C_FLOW] = cur[`LACM_C_FLOW] | (r.wd[2] == 12'(`LACM_FLOW_MS));
      cur[`LACM_C_UNLATCH] = cur[`LACM_C_UNLATCH] | ~r.fval[0];
      cur[`LACM_C_HOTSW]   = cur[`LACM_C_HOTSW] | ~r.fval[1];
      // warm-up and strike supervision
      if (r.st != LS_ON) n.warm_s = 8'h00;
      else if (s_tick && r.warm_s != 8'(`LACM_WARM_S)) n.warm_s = r.warm_s + 8'h01;
      cur[`LACM_C_WARM]   = cur[`LACM_C_WARM] | ((r.st == LS_ON) && (r.warm_s == 8'(`LACM_WARM_S)) &&
                            lamp_ignited && !lamp_ready);
      cur[`LACM_C_STRIKE] = cur[`LACM_C_STRIKE] | ((r.st == LS_ON) && (r.warm_s == 8'(`LACM_WARM_S)) &&
                            !lamp_ignited);
      // faults latch; a new fault wins over a software clear
      if (bus.wr && bus.addr == `LACM_A_CTRL && bus.wdata[`LACM_CTRL_CLR]) n.flt_lat = 23'h000000;
      n.flt_lat[22:7] = n.flt_lat[22:7] | cur[22:7];
      n.flt_lat[6:0] = 7'h00;
      act = {n.flt_lat[22:7], cur[6:0]};
      n.code = top_code(act);
      n.alarm = (n.code >= `LACM_C_FIRST_FLT);
      fault_any = |n.flt_lat[22:7];
      // lamp and cooldown sequencing
      req = r.pin[`LACM_P_LAMP];
      if (s_tick && r.st == LS_COOL) n.cool_s = r.cool_s + 16'h0001;
      if (r.vfd)
         cool_done = (r.cool_s >= 16'(`LACM_COOL_MAX_S)) ||
                     ((lamp_temp <= r.cool_param[11:0]) &&
                      (!r.low_at_off || r.cool_s > 16'(`LACM_COOL_MIN_S))); // first second may be short
      else cool_done = (r.cool_s >= r.cool_param);
      unique case (r.st)
         LS_OFF: if (req && !fault_any) n.st = LS_ON;
         LS_ON: if (!req || fault_any) begin
            n.st = LS_COOL;
            n.cool_s = 16'h0000;
            n.low_at_off = (lamp_temp < r.cool_param[11:0]);
         end
         LS_COOL: if (cool_done) n.st = LS_OFF;
      endcase
      // PI regulator on lamp air temperature, integral updated each ms, output each clock
      err = 13'(signed'({1'b0, lamp_temp})) - 13'(signed'({1'b0, r.setp}));
      pterm = 22'(err * signed'({1'b0, r.kp}));
      iterm = 22'(err * signed'({1'b0, r.ki}));
      isum = 23'(r.integ) + 23'(iterm >>> 4);
      if (r.st != LS_ON) n.integ = 16'sh0000;
      else if (ms_tick) begin
         if (isum > 23'sh007FFF) n.integ = 16'sh7FFF;
         else if (isum < -23'sh008000) n.integ = -16'sh8000;
         else n.integ = 16'(isum);
      end
      osum = 23'(pterm >>> 4) + 23'(r.integ);
      if (n.st == LS_COOL) n.air = 8'hFF;
      else if (n.st == LS_OFF) n.air = 8'h00;
      else if (osum > 23'sh0000FF) n.air = 8'hFF;
      else if (osum < 23'sh000000) n.air = 8'h00;
      else n.air = osum[7:0];
      // hour meter; a software write wins over the increment
      if (s_tick && r.st == LS_ON) begin
         if (r.s_in_hr == 12'(`LACM_SEC_PER_HR - 1)) begin
            n.s_in_hr = 12'h000;
            n.hours = r.hours + 20'h00001;
         end else n.s_in_hr = r.s_in_hr + 12'h001;
      end
      // register writes
      if (bus.wr) begin
         unique case (bus.addr)
            `LACM_A_CTRL:  n.vfd = bus.wdata[`LACM_CTRL_VFD];
            `LACM_A_COOL:  n.cool_param = bus.wdata[15:0];
            `LACM_A_KP:    n.kp = bus.wdata[7:0];
            `LACM_A_KI:    n.ki = bus.wdata[7:0];
            `LACM_A_SETP:  n.setp = bus.wdata[11:0];
            `LACM_A_HOURS: begin
               n.hours = bus.wdata[19:0];
               n.s_in_hr = 12'h000;
            end
            default: ;
         endcase
      end
      // read mux; unmapped words read zero
      unique case (bus.addr)
         `LACM_A_CTRL:  rmux = {31'h0, r.vfd};
         `LACM_A_COOL:  rmux = {16'h0, r.cool_param};
         `LACM_A_KP:    rmux = {24'h0, r.kp};
         `LACM_A_KI:    rmux = {24'h0, r.ki};
         `LACM_A_SETP:  rmux = {20'h0, r.setp};
         `LACM_A_HOURS: rmux = {12'h0, r.hours};
         `LACM_A_CODE:  rmux = {27'h0, r.code};
         `LACM_A_STAT:  rmux = {26'h0, r.low_at_off, r.st, r.alarm, r.st == LS_ON, r.st != LS_OFF};
         default:       rmux = 32'h0000_0000;
      endcase
      n.rdata = bus.rd ? rmux : 32'h0000_0000;
      // LED flash sequencer, code sampled at the start of each group
      if (r.lph == LP_ON) ph_len = (r.led_code == 5'h00) ? 11'(`LACM_FLICK_MS) : 11'(`LACM_LED_ON_MS);
      else if (r.lph == LP_OFF) ph_len = 11'(`LACM_LED_OFF_MS);
      else ph_len = 11'(`LACM_LED_GAP_MS);
      if (ms_tick) begin
         n.led_ms = r.led_ms + 11'h001;
         if (r.led_ms == ph_len - 11'h001) begin
            n.led_ms = 11'h000;
            unique case (r.lph)
               LP_GAP: begin
                  n.lph = LP_ON;
                  n.led_i = 5'h00;
                  n.led_code = r.code;
               end
               LP_ON: n.lph = LP_OFF;
               LP_OFF: begin
                  if (r.led_i + 5'h01 == flashes(r.led_code)) n.lph = LP_GAP;
                  else begin
                     n.lph = LP_ON;
                     n.led_i = r.led_i + 5'h01;
                  end
               end
            endcase
         end
      end
      // colour: green events, alternating warnings, red faults
      n.led_g = (n.lph == LP_ON) && ((n.led_code <= 5'h02) ||
                (n.led_code <= 5'h06 && !n.led_i[0]));
      n.led_r = (n.lph == LP_ON) && ((n.led_code >= `LACM_C_FIRST_FLT) ||
                (n.led_code >= 5'h03 && n.led_i[0]));
   end

   // single state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
         r.st <= LS_OFF;
         r.lph <= LP_GAP;
         r.fval <= 2'h3;
         r.cool_param <= `LACM_RST_COOL;
         r.kp <= `LACM_RST_KP;
         r.ki <= `LACM_RST_KI;
         r.setp <= `LACM_RST_SETP;
      end else r <= n;
   end

   assign rdata      = r.rdata;
   assign lamp_on    = (r.st == LS_ON);
   assign blower_on  = (r.st != LS_OFF);
   assign airflow    = r.air;
   assign alarm_out  = r.alarm;
   assign fault_code = r.code;
   assign lamp_hours = r.hours;
   assign led_green  = r.led_g;
   assign led_red    = r.led_r;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_COOL_FULL_AIR: assert property ($fell(lamp_on) |-> airflow == 8'hFF && blower_on)
      else $error("cooldown not at full airflow");
   AST_DAMPER_END: assert property ((r.st == LS_COOL && !r.vfd && r.cool_s >= r.cool_param)
      |=> !blower_on) else $error("damper cooldown overran");
   AST_VFD_CAP: assert property ((r.st == LS_COOL && r.vfd) |-> r.cool_s <= 16'(`LACM_COOL_MAX_S))
      else $error("vfd cooldown beyond cap");
   AST_VFD_MIN: assert property ((r.st == LS_COOL && r.vfd && r.low_at_off && r.cool_s < 16'(`LACM_COOL_MIN_S))
      |=> blower_on && airflow == 8'hFF) else $error("vfd minimum cooldown cut short");
   AST_HOT_SWITCH: assert property ((!r.fval[1] && lamp_on) |=> !lamp_on && fault_code >= 5'(`LACM_C_HOTSW))
      else $error("hot switch did not shut lamp");
   AST_HOURS_WRITE: assert property ((bus.wr && bus.addr == `LACM_A_HOURS)
      |=> lamp_hours == $past(bus.wdata[19:0])) else $error("hour meter write lost");
   AST_FAULT_OFF: assert property (alarm_out |-> !lamp_on) else $error("lamp on during fault");
   // the led follows the code sampled at group start, not the live code
   AST_IDLE: assert property ((fault_code == 5'h00 |-> !alarm_out) and (r.led_code == 5'h00 |-> !led_red))
      else $error("idle shows alarm");
   AST_FAULT_RED: assert property ((led_green || led_red) && r.led_code >= `LACM_C_FIRST_FLT |-> !led_green)
      else $error("fault flashed green");
   AST_FAN_TIMEOUT: assert property ((r.wd[1] == 12'(`LACM_FB_MS)) |=> alarm_out && !lamp_on)
      else $error("fan watchdog did not shut lamp");
   AST_GAP_DARK: assert property ((r.lph == LP_GAP) |-> !led_green && !led_red) else $error("led lit in pause");

   COV_VFD_COOL: cover property (r.st == LS_COOL && r.vfd ##1 r.st == LS_OFF);
   COV_FAULT: cover property ($rose(alarm_out));
   COV_WARN_RED: cover property (led_red && !alarm_out);
   COV_HOURS: cover property (bus.wr && bus.addr == `LACM_A_HOURS);
endmodule // lacm_top

//--- testbench/lacm_partner.sv
// lacm_partner: behavioural lamp housing switches and blower drive
// assumes the manager's clock; an open contact reads high through its pull-up
`timescale 1ns/1ps
module lacm_partner #(
   parameter int FB_DLY = 40
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic blower_on,
   input  wire logic shutter_cmd,
   input  wire logic fan_dead,
   input  wire logic therm_open,
   output logic      interlock_n,
   output logic      lamp_sw_n,
   output logic      shutter_open_n,
   output logic      fan_fb_n,
   output logic      flow_ok_n
);
   int unsigned fan_cnt;
   // cassette latched, airflow good; thermal contact opens only on command
   assign interlock_n = 1'b0;
   assign flow_ok_n   = 1'b0;
   assign lamp_sw_n   = therm_open;
   // shutter travels in one cycle; fan answers slowly, a dead fan never does
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fan_cnt        <= 0;
         fan_fb_n       <= 1'b1;
         shutter_open_n <= 1'b1;
      end else begin
         shutter_open_n <= !shutter_cmd;
         fan_cnt        <= (blower_on && !fan_dead) ? fan_cnt + 1 : 0;
         fan_fb_n       <= !(fan_cnt >= FB_DLY);
      end
   end
endmodule // lacm_partner

//--- testbench/lacm_top_bench.sv
// lacm_top_bench: self-checking bench of the alarm and cooldown manager
// assumes lacm_top with a shortened millisecond; register reads are scoreboarded
`timescale 1ns/1ps
`include "lacm_map.svh"
module lacm_top_bench;
   import lacm_pkg::*;
   localparam int MS  = 1;
   localparam int S   = 1000 * MS;
   localparam int GAP = 400 * MS;
   logic        clk, rst, lamp_en_n, shutter_cmd, lamp_ignited, lamp_ready, rd_seen;
   logic        fan_dead, therm_open, interlock_n, lamp_sw_n, shutter_open_n, fan_fb_n, flow_ok_n;
   logic        lamp_on, blower_on, alarm_out, led_green, led_red;
   lacm_bus_t   bus;
   logic [31:0] rdata, hrs;
   logic [11:0] lamp_temp;
   logic [22:0] cond_in;
   logic [7:0]  airflow;
   logic [4:0]  fault_code;
   logic [19:0] lamp_hours;
   logic [31:0] exp_q[$];
   int          err_count, compares, cyc, i, g, r, n;

   lacm_top #(.MS_CYC(MS)) dut_u (
      .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .lamp_en_n(lamp_en_n),
      .interlock_n(interlock_n), .lamp_sw_n(lamp_sw_n), .shutter_open_n(shutter_open_n),
      .fan_fb_n(fan_fb_n), .flow_ok_n(flow_ok_n), .shutter_cmd(shutter_cmd),
      .lamp_ignited(lamp_ignited), .lamp_ready(lamp_ready), .lamp_temp(lamp_temp),
      .cond_in(cond_in), .lamp_on(lamp_on), .blower_on(blower_on), .airflow(airflow),
      .alarm_out(alarm_out), .fault_code(fault_code), .lamp_hours(lamp_hours),
      .led_green(led_green), .led_red(led_red));

   lacm_partner part_u (
      .clk(clk), .rst(rst), .blower_on(blower_on), .shutter_cmd(shutter_cmd),
      .fan_dead(fan_dead), .therm_open(therm_open), .interlock_n(interlock_n),
      .lamp_sw_n(lamp_sw_n), .shutter_open_n(shutter_open_n), .fan_fb_n(fan_fb_n),
      .flow_ok_n(flow_ok_n));

   task automatic report_and_stop();
      if (err_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   // one-cycle strobes, changed right after an edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge clk);
      bus.wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      bus.rd   <= 1'b0;
   endtask

   task automatic lamp_set(input logic on);
      @(posedge clk);
      lamp_en_n    <= !on;
      lamp_ignited <= on;
      lamp_ready   <= on;
      shutter_cmd  <= on;
      for (i = 0; i < 20 && lamp_on !== on; i++) @(posedge clk);
      repeat (2) @(posedge clk);
   endtask

   task automatic wait_cool();
      for (i = 0; i < 3 * S && blower_on !== 1'b0; i++) @(posedge clk);
   endtask

   // length of a cooldown and cycles spent below full airflow
   task automatic cool_run(input int lim, output int cn, output int bad);
      cn = 0;
      bad = 0;
      while (blower_on === 1'b1 && cn < lim) begin
         if (airflow !== 8'hFF) bad++;
         @(posedge clk);
         cn++;
      end
   endtask

   // count one flash group, synchronised on the long dark pause
   task automatic led_group(output int gc, output int rc);
      int   dark;
      logic pg, pr;
      gc = 0;
      rc = 0;
      dark = 0;
      pg = 1'b0;
      pr = 1'b0;
      while (dark < GAP) begin
         @(posedge clk);
         dark = ((led_green | led_red) === 1'b0) ? dark + 1 : 0;
      end
      while ((led_green | led_red) !== 1'b1) @(posedge clk);
      dark = 0;
      while (dark < GAP) begin
         if (led_green === 1'b1 && !pg) gc++;
         if (led_red === 1'b1 && !pr) rc++;
         pg = (led_green === 1'b1);
         pr = (led_red === 1'b1);
         dark = ((led_green | led_red) === 1'b0) ? dark + 1 : 0;
         @(posedge clk);
      end
   endtask

   // clock, 20 ns period
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_seen === 1'b1) begin
         if (exp_q.size() == 0) check(1'b0, "unexpected read");
         else check(rdata === exp_q.pop_front(), "read data");
      end
      rd_seen <= bus.rd;
   end

   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 100000) begin
         err_count++;
         $display("MISMATCH %0t timeout", $time);
         report_and_stop();
      end
   end

   initial begin
      hrs = $urandom(32'h1FCA);
      rst = 1'b1;
      bus = '0;
      rd_seen = 1'b0;
      lamp_en_n = 1'b1;
      {shutter_cmd, lamp_ignited, lamp_ready, fan_dead, therm_open} = '0;
      lamp_temp = 12'($urandom);
      cond_in = '0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      // reset values, read-only and unmapped places
      rd(`LACM_A_COOL, 32'(`LACM_RST_COOL));
      rd(`LACM_A_KP, 32'(`LACM_RST_KP));
      rd(`LACM_A_KI, 32'(`LACM_RST_KI));
      rd(`LACM_A_SETP, 32'(`LACM_RST_SETP));
      wr(`LACM_A_CODE, 32'h1F);
      rd(`LACM_A_CODE, 32'h0);
      rd(8'h20, 32'h0);
      wr(`LACM_A_KP, 32'hA5);
      rd(`LACM_A_KP, 32'hA5);
      wr(`LACM_A_COOL, 32'h2);
      // hour meter preset and clear
      hrs = $urandom & 32'hFFFFF;
      wr(`LACM_A_HOURS, hrs);
      @(posedge clk);
      check(lamp_hours === hrs[19:0], "hours preset");
      rd(`LACM_A_HOURS, hrs);
      wr(`LACM_A_HOURS, 32'h0);
      rd(`LACM_A_HOURS, 32'h0);
      // events and warnings are live and never raise the alarm
      for (int c = 1; c <= 6; c++) begin
         cond_in <= 23'h1 << c;
         repeat (3) @(posedge clk);
         check(fault_code === 5'(c) && alarm_out === 1'b0, "event code");
      end
      cond_in <= 23'h24;
      repeat (3) @(posedge clk);
      check(fault_code === 5'h5, "priority");
      cond_in <= 23'h10;
      led_group(g, r);
      check(g == 1 && r == 1, "warning flashes");
      cond_in <= '0;
      led_group(g, r);
      check(g == 1 && r == 0 && fault_code === 5'h0 && alarm_out === 1'b0, "idle");
      // every fault code latches, alarms and clears
      for (int c = 7; c <= 22; c++) begin
         cond_in <= 23'h1 << c;
         @(posedge clk);
         cond_in <= '0;
         repeat (3) @(posedge clk);
         check(fault_code === 5'(c) && alarm_out === 1'b1, "fault code");
         wr(`LACM_A_CTRL, 32'h2);
         repeat (2) @(posedge clk);
         check(fault_code === 5'h0 && alarm_out === 1'b0, "fault clear");
      end
      cond_in <= 23'h200;
      led_group(g, r);
      check(g == 0 && r == 3, "fault flashes");
      cond_in <= '0;
      wr(`LACM_A_CTRL, 32'h2);
      wait_cool();
      // damper cooldown holds full airflow for the programmed seconds
      lamp_set(1'b1);
      check(lamp_on === 1'b1 && blower_on === 1'b1, "lamp start");
      repeat (100) @(posedge clk);
      lamp_set(1'b0);
      check(lamp_on === 1'b0 && blower_on === 1'b1 && airflow === 8'hFF, "cool start");
      cool_run(3 * S, n, g);
      check(n >= S && n <= 2 * S + 20 && g == 0, "damper hold");
      // vfd cooldown: a cool lamp still gets the minimum run, a hot one stops at the set temperature
      wr(`LACM_A_CTRL, 32'h1);
      wr(`LACM_A_COOL, 32'h200);
      lamp_temp <= 12'($urandom % 32'h200);
      lamp_set(1'b1);
      repeat (100) @(posedge clk);
      lamp_set(1'b0);
      cool_run(40 * S, n, g);
      check(n >= 30 * S && n <= 31 * S + 20 && g == 0, "vfd minimum");
      lamp_temp <= 12'h201 + 12'($urandom % 32'h100);
      lamp_set(1'b1);
      repeat (100) @(posedge clk);
      lamp_set(1'b0);
      repeat (2 * S) @(posedge clk);
      check(blower_on === 1'b1 && airflow === 8'hFF, "vfd hot hold");
      lamp_temp <= 12'($urandom % 32'h201);
      repeat (3) @(posedge clk);
      check(blower_on === 1'b0, "vfd set temperature");
      wr(`LACM_A_CTRL, 32'h0);
      wr(`LACM_A_COOL, 32'h2);
      // thermal switch opening while lit
      lamp_set(1'b1);
      repeat (100) @(posedge clk);
      therm_open <= 1'b1;
      repeat (270 * MS) @(posedge clk);
      check(alarm_out === 1'b0, "thermal early");
      for (i = 0; i < 100 * MS && alarm_out !== 1'b1; i++) @(posedge clk);
      @(posedge clk);
      check(fault_code === 5'h13 && lamp_on === 1'b0 && blower_on === 1'b1 && airflow === 8'hFF,
            "thermal fault");
      therm_open <= 1'b0;
      lamp_set(1'b0);
      wait_cool();
      repeat (350 * MS) @(posedge clk);
      wr(`LACM_A_CTRL, 32'h2);
      rd(`LACM_A_CODE, 32'h0);
      // blower feedback never arrives
      fan_dead <= 1'b1;
      lamp_set(1'b1);
      repeat (1900 * MS) @(posedge clk);
      check(alarm_out === 1'b0, "fan early");
      for (i = 0; i < 300 * MS && alarm_out !== 1'b1; i++) @(posedge clk);
      @(posedge clk);
      check(fault_code === 5'h15 && lamp_on === 1'b0, "fan fault");
      repeat (4) @(posedge clk);
      report_and_stop();
   end
endmodule // lacm_top_bench
